// ---- logic/thbsc_serial_ctrl.sv ----
// Serial command interface and control of a triple half-bridge driver
`timescale 1ns/1ns
module thbsc_serial_ctrl (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic linkClk,
	input wire logic chipSelN,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEnN,
	input wire logic hwEnable,
	input wire thbsc_pkg::thbsc_sense_t sense,
	output thbsc_pkg::thbsc_switch_t switches,
	output logic openLoadCheckEn,
	output logic shortTripLong,
	output logic faultOut,
	output logic faultOutEnN
);
	// Link domain state, clocked by the serial clock
	typedef struct packed {
		logic [thbsc_pkg::CountBits-1:0] count;
	} thbsc_link_t;

	// Shift register kept apart from the count so that chip select
	// rising cannot wipe the word before the system side takes it
	logic [thbsc_pkg::WordBits-1:0] cmdShift_r;
	logic [thbsc_pkg::WordBits-1:0] cmdShift_nxt;

	typedef struct packed {
		logic [thbsc_pkg::WordBits-1:0] shiftOut;
		logic started;
	} thbsc_linkr_t;

	// System domain state
	typedef struct packed {
		logic [1:0] csSync;
		logic csHeld;
		logic [thbsc_pkg::WordBits-1:0] cmd;
		logic [thbsc_pkg::WordBits-1:0] status;
		logic supplyFail;
		logic shortFlag;
		logic overTempLatch;
		logic [1:0] enSync;
		thbsc_pkg::thbsc_sense_t senseMeta;
		thbsc_pkg::thbsc_sense_t senseSync;
		logic faultDrive;
		thbsc_pkg::thbsc_switch_t sw;
		logic olCheck;
		logic tripLong;
	} thbsc_sys_t;

	thbsc_link_t lnk_r, lnk_nxt;
	thbsc_linkr_t lro_r, lro_nxt;
	thbsc_sys_t st_r, st_nxt;

	// Shift in on falling serial clock; chip select high clears count
	always_comb begin
		lnk_nxt = lnk_r;
		cmdShift_nxt = cmdShift_r;
		// Bits past the sixteenth are dropped
		if (lnk_r.count != thbsc_pkg::LastBit + 5'h01) begin
			// LSB arrives first, so shift toward bit 0
			cmdShift_nxt = {serialIn,
				cmdShift_r[thbsc_pkg::WordBits-1:1]};
			lnk_nxt.count = lnk_r.count + 5'h01;
		end
	end

	// Word holds after the frame; the clock stands still until the next
	always_ff @(negedge linkClk) begin
		cmdShift_r <= cmdShift_nxt;
	end

	// Count is cleared asynchronously by chip select: the serial clock
	// may stand still between frames, so only the frame edge can end it.
	always_ff @(negedge linkClk or posedge chipSelN) begin
		if (chipSelN) begin
			lnk_r <= '0;
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// Status snapshot is taken at chip select fall; later bits shift out
	always_comb begin
		lro_nxt = lro_r;
		lro_nxt.started = 1'b1;
		if (!lro_r.started) begin
			// Bit 0 already stands; first rise moves on to bit 1
			lro_nxt.shiftOut = statusShift;
		end else begin
			lro_nxt.shiftOut = {1'b0,
				lro_r.shiftOut[thbsc_pkg::WordBits-1:1]};
		end
	end

	// Status held stable in system domain while chip select low
	always_ff @(posedge linkClk or posedge chipSelN) begin
		if (chipSelN) begin
			lro_r <= '0;
		end else begin
			lro_r <= lro_nxt;
		end
	end

	// First bit comes from the held status before any rising edge
	always_comb begin
		serialOut = lro_r.started ? lro_r.shiftOut[0]
			: st_r.status[thbsc_pkg::BitTempWarn];
		serialOutEnN = chipSelN;
	end

	// First rising edge loads bit 1 of the frozen status
	logic [thbsc_pkg::WordBits-1:0] statusShift;
	assign statusShift = {1'b0, st_r.status[thbsc_pkg::WordBits-1:1]};

	// Status composed combinationally from the applied command and flags
	function automatic logic [thbsc_pkg::WordBits-1:0] make_status(
		input thbsc_sys_t s,
		input thbsc_pkg::thbsc_sense_t n,
		input logic en
	);
		logic [thbsc_pkg::WordBits-1:0] w;
		logic [5:0] sw;
		w = thbsc_pkg::ZeroWord;
		sw = s.sw | (s.olCheck ? n.openLoad : 6'h00);
		w[thbsc_pkg::BitTempWarn] = n.tempWarn;
		w[thbsc_pkg::BitLs1] = sw[5];
		w[thbsc_pkg::BitHs1] = sw[4];
		w[thbsc_pkg::BitLs2] = sw[3];
		w[thbsc_pkg::BitHs2] = sw[2];
		w[thbsc_pkg::BitLs3] = sw[1];
		w[thbsc_pkg::BitHs3] = sw[0];
		w[thbsc_pkg::BitShortFlag] = s.shortFlag;
		w[thbsc_pkg::BitEnable] = en;
		w[thbsc_pkg::BitSupplyFail] = s.supplyFail;
		if (s.overTempLatch) begin
			w = thbsc_pkg::AllOnes;
		end
		return w;
	endfunction : make_status

	// Switch fields of a command word, in the order of the switch struct
	function automatic thbsc_pkg::thbsc_switch_t cmd_switches(
		input logic [thbsc_pkg::WordBits-1:0] c
	);
		thbsc_pkg::thbsc_switch_t s;
		s.lowSideSwitch1 = c[thbsc_pkg::BitLs1];
		s.highSideSwitch1 = c[thbsc_pkg::BitHs1];
		s.lowSideSwitch2 = c[thbsc_pkg::BitLs2];
		s.highSideSwitch2 = c[thbsc_pkg::BitHs2];
		s.lowSideSwitch3 = c[thbsc_pkg::BitLs3];
		s.highSideSwitch3 = c[thbsc_pkg::BitHs3];
		return s;
	endfunction : cmd_switches

	logic enBoth;
	logic csRise;
	logic [thbsc_pkg::WordBits-1:0] newCmd;

	always_comb begin
		st_nxt = st_r;
		st_nxt.csSync = {st_r.csSync[0], chipSelN};
		st_nxt.csHeld = st_r.csSync[1];
		st_nxt.enSync = {st_r.enSync[0], hwEnable};
		// Sense levels come from analog circuits on no clock of ours
		st_nxt.senseMeta = sense;
		st_nxt.senseSync = st_r.senseMeta;
		csRise = st_r.csSync[1] && !st_r.csHeld;
		newCmd = cmdShift_r;

		// Word is complete and stable once chip select is high again
		if (csRise) begin
			st_nxt.cmd = newCmd & thbsc_pkg::CmdKeepMask;
		end

		// Latched flags: a new event wins over a clear
		if (csRise && newCmd[thbsc_pkg::BitClear]) begin
			st_nxt.supplyFail = 1'b0;
			st_nxt.shortFlag = 1'b0;
			st_nxt.overTempLatch = 1'b0;
		end
		if (st_r.senseSync.underVolt) begin
			st_nxt.supplyFail = 1'b1;
		end
		if (st_r.senseSync.shortEvent) begin
			st_nxt.shortFlag = 1'b1;
		end
		if (st_r.senseSync.overTemp) begin
			st_nxt.overTempLatch = 1'b1;
		end

		// Either enable low turns every stage off; shifting goes on
		enBoth = st_r.enSync[1]
			&& st_r.cmd[thbsc_pkg::BitSwEnable];
		if (enBoth) begin
			st_nxt.sw = cmd_switches(st_r.cmd);
		end else begin
			st_nxt.sw = '0;
		end
		st_nxt.olCheck = !st_r.cmd[thbsc_pkg::BitOpenLoadN];
		st_nxt.tripLong = st_r.cmd[thbsc_pkg::BitTripSel];
		st_nxt.faultDrive = st_r.senseSync.overTemp
			|| st_r.senseSync.overCurrent;

		// Status frozen while a frame runs so outgoing bits stay coherent
		if (st_r.csSync[1]) begin
			st_nxt.status = make_status(st_r, st_r.senseSync,
				enBoth);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.csSync <= 2'h3;
			st_r.csHeld <= 1'b1;
			st_r.cmd <= thbsc_pkg::CmdReset;
			st_r.olCheck <= 1'b0;
			st_r.tripLong <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		switches = st_r.sw;
		openLoadCheckEn = st_r.olCheck;
		shortTripLong = st_r.tripLong;
		faultOut = 1'b0;
		faultOutEnN = !st_r.faultDrive;
	end
endmodule : thbsc_serial_ctrl

// ---- logic/thbsc_pkg.sv ----
// Package for the triple half-bridge serial control block
package thbsc_pkg;
	localparam int WordBits = 16;
	localparam int CountBits = 5;
	localparam logic [CountBits-1:0] LastBit = 5'h0f;
	localparam logic [CountBits-1:0] CountZero = 5'h00;
	localparam int BitClear = 0;
	localparam int BitLs1 = 3;
	localparam int BitHs1 = 4;
	localparam int BitLs2 = 7;
	localparam int BitHs2 = 8;
	localparam int BitLs3 = 11;
	localparam int BitHs3 = 12;
	localparam int BitOpenLoadN = 13;
	localparam int BitTripSel = 14;
	localparam int BitSwEnable = 15;
	localparam int BitTempWarn = 0;
	localparam int BitShortFlag = 13;
	localparam int BitEnable = 14;
	localparam int BitSupplyFail = 15;
	localparam logic [WordBits-1:0] CmdReset = 16'he000;
	localparam logic [WordBits-1:0] SwitchMask = 16'h1998;
	localparam logic [WordBits-1:0] AllOnes = 16'hffff;
	localparam logic [WordBits-1:0] ZeroWord = 16'h0000;
	// Clear, switch and setting bits; unused positions read as zero
	localparam logic [WordBits-1:0] CmdKeepMask = 16'hf999;
	localparam int TripLongUs = 12000;
	localparam int TripShortUs = 1500;

	typedef struct packed {
		logic lowSideSwitch1;
		logic highSideSwitch1;
		logic lowSideSwitch2;
		logic highSideSwitch2;
		logic lowSideSwitch3;
		logic highSideSwitch3;
	} thbsc_switch_t;

	typedef struct packed {
		logic tempWarn;
		logic overTemp;
		logic shortEvent;
		logic underVolt;
		logic overCurrent;
		logic [5:0] openLoad;
	} thbsc_sense_t;
endpackage : thbsc_pkg

// ---- test/thbsc_serial_ctrl_properties.sv ----
// Port checker for the serial control block
`timescale 1ns/1ns
module thbsc_serial_ctrl_properties (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chipSelN,
	input wire logic serialOutEnN,
	input wire logic hwEnable,
	input wire thbsc_pkg::thbsc_sense_t sense,
	input wire thbsc_pkg::thbsc_switch_t switches,
	input wire logic openLoadCheckEn,
	input wire logic shortTripLong,
	input wire logic faultOut,
	input wire logic faultOutEnN
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Five cycles cover the two-flop sync and the output register
	sequence sHwOff;
		!hwEnable [*5];
	endsequence
	sequence sFault;
		(sense.overTemp || sense.overCurrent) [*5];
	endsequence
	sequence sFrame;
		!chipSelN [*6];
	endsequence
	chk_oe_level: assert property (
		serialOutEnN == chipSelN) else $error("oe level");
	chk_oe_start: assert property (
		$fell(chipSelN) |-> !serialOutEnN) else $error("oe start");
	chk_fault_drive: assert property (
		faultOut == 1'b0) else $error("fault level");
	chk_fault_pull: assert property (
		sFault |-> !faultOutEnN) else $error("fault pin");
	chk_hw_off: assert property (
		sHwOff |-> switches == '0) else $error("hw standby");
	chk_cfg_late: assert property (
		($changed(openLoadCheckEn) || $changed(shortTripLong))
		|-> $past(chipSelN, 2)) else $error("cfg early");
	chk_sw_late: assert property (
		($changed(switches) && hwEnable && $past(hwEnable, 6))
		|-> $past(chipSelN, 2)) else $error("switch early");
	chk_frame_hold: assert property (
		sFrame |-> $stable(shortTripLong) && $stable(openLoadCheckEn))
		else $error("cfg in frame");
endmodule : thbsc_serial_ctrl_properties
bind thbsc_serial_ctrl thbsc_serial_ctrl_properties i_chk (.clk, .sys_rst,
	.chipSelN, .serialOutEnN, .hwEnable, .sense, .switches,
	.openLoadCheckEn, .shortTripLong, .faultOut, .faultOutEnN);

// ---- test/thbsc_host_model.sv ----
// Host serial master model
`timescale 1ns/1ns
module thbsc_host_model (
	output logic linkClk,
	output logic chipSelN,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEnN
);
	// Clock idles high so status bit0 is read before any shift
	initial begin
		linkClk = 1'b1;
		chipSelN = 1'b1;
		serialIn = 1'b0;
	end
	task automatic xfer(input logic [15:0] c, output logic [15:0] s);
		chipSelN = 1'b0;
		for (int i = 0; i < 16; i++) begin
			serialIn = c[i];
			#16 linkClk = 1'b0;
			s[i] = serialOut;
			#16 linkClk = 1'b1;
		end
		#16 chipSelN = 1'b1;
		serialIn = 1'b0;
		#400;
	endtask : xfer
endmodule : thbsc_host_model

// ---- test/thbsc_serial_ctrl_tb.sv ----
// Bench for the serial control block
`timescale 1ns/1ns
module thbsc_serial_ctrl_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hwEnable = 1'b1;
	thbsc_pkg::thbsc_sense_t sense = '0;
	thbsc_pkg::thbsc_switch_t switches;
	logic linkClk, chipSelN, serialIn, serialOut, serialOutEnN;
	logic openLoadCheckEn, shortTripLong, faultOut, faultOutEnN;
	logic [15:0] st;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	thbsc_serial_ctrl i_dut (.clk, .sys_rst, .linkClk, .chipSelN, .serialIn,
		.serialOut, .serialOutEnN, .hwEnable, .sense, .switches,
		.openLoadCheckEn, .shortTripLong, .faultOut, .faultOutEnN);
	thbsc_host_model i_host (.linkClk, .chipSelN, .serialIn, .serialOut,
		.serialOutEnN);
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic fr(input logic [15:0] c);
		i_host.xfer(c, st);
	endtask : fr
	task automatic sn(input logic [10:0] v);
		@(posedge clk) sense <= v;
		wt(6);
	endtask : sn
	function automatic logic [15:0] cf();
		return {7'h00, openLoadCheckEn, shortTripLong, 1'b0, switches};
	endfunction : cf
	task automatic t_sw;
		int b[6] = '{3, 4, 7, 8, 11, 12};
		chk("rst", 16'h0080, cf());
		for (int k = 0; k < 6; k++) begin
			fr(16'ha666 | 16'h0001 << b[k]);
			chk("sw", 16'h0020 >> k, cf());
			fr(16'ha000);
			chk("sws", 16'h4000 | 16'h0001 << b[k], st);
		end
	endtask : t_sw
	task automatic t_stby;
		fr(16'h4018);
		chk("stby", 16'h0180, cf());
		fr(16'ha018);
		chk("stbys", 16'h0000, st);
		chk("on", 16'h0030, cf());
		@(posedge clk) hwEnable <= 1'b0;
		wt(6);
		chk("hwoff", 16'h0000, cf());
		fr(16'ha018);
		chk("hws", 16'h0000, st);
		@(posedge clk) hwEnable <= 1'b1;
		wt(6);
		chk("hwon", 16'h0030, cf());
	endtask : t_stby
	task automatic t_flag;
		sn(11'h580);
		sn(11'h400);
		fr(16'ha001);
		chk("flag", 16'he019, st);
		fr(16'ha000);
		chk("clr", 16'h4001, st);
		sn(11'h200);
		chk("otp", 16'h0000, {14'h0, faultOut, faultOutEnN});
		fr(16'ha000);
		chk("ota", 16'hffff, st);
		sn(11'h040);
		fr(16'ha001);
		chk("ocp", 16'h0000, {14'h0, faultOut, faultOutEnN});
		sn(11'h000);
		chk("rel", 16'h0001, {14'h0, faultOut, faultOutEnN});
	endtask : t_flag
	initial begin
		wt(2);
		sys_rst <= 1'b0;
		wt(4);
		t_sw();
		t_stby();
		t_flag();
		conclude();
	end
endmodule : thbsc_serial_ctrl_tb
